// file: logic/pxa_pkg.sv
// Package with register map, field positions, reset values and command codes
package pxa_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_DIMS   = 8'h00;
    localparam logic [7:0] OFF_BG     = 8'h04;
    localparam logic [7:0] OFF_FG     = 8'h08;
    localparam logic [7:0] OFF_WINDOW_START_CORNER = 8'h10;
    localparam logic [7:0] OFF_WINDOW_END_CORNER   = 8'h14;
    localparam logic [7:0] OFF_DESTINATION_ADDRESS  = 8'h18;
    localparam logic [7:0] OFF_CTRL   = 8'h1C;
    localparam logic [7:0] OFF_CMD    = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;
    localparam logic [7:0] OFF_SRC    = 8'h28;
    localparam logic [7:0] OFF_WORD   = 8'h2C;
    localparam logic [7:0] OFF_SCR    = 8'h30;
    localparam logic [7:0] OFF_WSIZE  = 8'h44;
    localparam logic [7:0] OFF_COUNT  = 8'h48;
    // Scratch bank: five words, the line pattern is the fourth
    localparam int         SCR_N      = 5;
    localparam int         PAT_IDX    = 3;
    localparam int         XCNT_IDX   = 0;
    localparam int         YCNT_IDX   = 1;
    // Field positions
    localparam int         HI_LSB     = 16;
    localparam int         HALF_W     = 16;
    localparam int         BG_BITS    = 16;
    localparam int         ST_BUSY    = 0;
    localparam int         ST_EMPTY   = 1;
    localparam int         ST_OVF     = 28;
    localparam int         PS_W       = 3;
    // Reset values
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [2:0]  RST_PS    = 3'h2;
    // Commands written to the command register
    localparam logic [2:0]  CMD_CLIP  = 3'h1;
    localparam logic [2:0]  CMD_FILL  = 3'h2;
    localparam logic [2:0]  CMD_EXP   = 3'h3;
    localparam logic [2:0]  CMD_DRAW  = 3'h4;
endpackage : pxa_pkg

// file: logic/pxa_expand.sv
// Binary to colour expansion of one source word into one pixel word
`timescale 1ns/100ps
module pxa_expand (
    // Colours and pixel size code (pixel bits = 1 << ps)
    input  wire logic [31:0] fg,
    input  wire logic [31:0] bg,
    input  wire logic [2:0]  ps,
    // One source bit per destination pixel, lowest pixel first
    input  wire logic [31:0] src,
    // Expanded destination word
    output logic      [31:0] word
);
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : g_bit
            wire [4:0] pix_idx;
            assign pix_idx = 5'(i >> ps);
            // Bit i keeps its own alignment in the foreground word; the background bit is i modulo 16
            assign word[i] = src[pix_idx] ? fg[i]
                                          : bg[i % pxa_pkg::BG_BITS];
        end
    endgenerate
endmodule : pxa_expand

// file: logic/pxa_clip.sv
// Common rectangle of destination array and clipping window
`timescale 1ns/100ps
module pxa_clip (
    // Destination corner and size, X low half, Y high half
    input  wire logic [31:0] destination_address,
    input  wire logic [31:0] dims,
    // Window corners, both inclusive
    input  wire logic [31:0] window_start_corner,
    input  wire logic [31:0] window_end_corner,
    // Result
    output logic             overlap,
    output logic      [31:0] common
);
    logic [16:0] d0 [2];
    logic [16:0] d1 [2];
    logic [16:0] lo [2];
    logic [16:0] hi [2];
    logic [1:0]  ok;
    genvar a;
    generate
        for (a = 0; a < 2; a = a + 1) begin : g_axis
            wire [16:0] ds;
            wire [16:0] sz;
            wire [16:0] ws;
            wire [16:0] we;
            assign ds    = {1'b0, destination_address[a*16 +: 16]};
            assign sz    = {1'b0, dims[a*16 +: 16]};
            assign ws    = {1'b0, window_start_corner[a*16 +: 16]};
            assign we    = {1'b0, window_end_corner[a*16 +: 16]};
            assign d0[a] = ds;
            assign d1[a] = ds + sz - 17'h00001;
            assign lo[a] = (d0[a] > ws) ? d0[a] : ws;
            assign hi[a] = (d1[a] < we) ? d1[a] : we;
            assign ok[a] = (sz != 17'h00000) && (lo[a] <= hi[a]);
            assign common[a*16 +: 16] = 16'(hi[a] - lo[a] + 17'h00001);
        end
    endgenerate
    assign overlap = &ok;
endmodule : pxa_clip

// file: logic/pxa_regs.sv
// Pixel array operand registers with APB access and a small operation engine
//
// What this block does
// - Dimension register: height in bits 31..16, width in bits 15..0.
// - Zero width or zero height means an empty array; nothing transferred.
// - Width and height each accepted up to 65,535.
// - Window size is end minus start plus one, on both axes.
// - Clip command writes the window/destination intersection size; draws nothing.
// - No overlap: overflow is cleared, dimension contents undefined.
// - Only software writes and the clip command change the dimension register.
// - Expansion zero bits take background pixels from its low 16 bits.
// - Foreground pixels are used at the same bit alignment as the destination.
// - Fill and draw operations use the foreground colour.
// - Expansion one bits take the aligned foreground pixel.
// - Operations never change either colour register.
// - Scratch words serve line operands; words 0 and 1 are overwritten by fill, expand and draw.
// - Window start and end corners are both inside the window.
// - Overflow is status bit 28, updated by operations.
`timescale 1ns/100ps
module pxa_regs (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Engine state
    output logic             busy,
    output logic             overflow
);
    typedef enum logic [1:0] {
        PXA_IDLE,
        PXA_RUN
    } pxa_state_e;

    pxa_state_e  state_r;
    pxa_state_e  state_nxt;
    logic [31:0] dims_r;
    logic [31:0] bg_r;
    logic [31:0] fg_r;
    logic [31:0] window_start_corner_r;
    logic [31:0] window_end_corner_r;
    logic [31:0] destination_address_r;
    logic [2:0]  ps_r;
    logic [31:0] src_r;
    logic [31:0] word_r;
    logic [31:0] count_r;
    logic [31:0] scr_r [pxa_pkg::SCR_N];
    logic        expand_r;
    logic        empty_r;
    logic        ovf_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic        busy_r;

    // Bus decode
    wire         setup_rd;
    wire         access;
    wire         wr_en;
    wire         hit;
    wire [31:0]  rd_mux;
    wire         sel_dims;
    wire         sel_bg;
    wire         sel_fg;
    wire         sel_window_start_corner;
    wire         sel_window_end_corner;
    wire         sel_destination_address;
    wire         sel_ctrl;
    wire         sel_cmd;
    wire         sel_status;
    wire         sel_src;
    wire         sel_word;
    wire         sel_wsize;
    wire         sel_count;
    wire         sel_scr;
    wire [2:0]   scr_idx;
    wire [7:0]   scr_off;

    assign setup_rd   = psel && !penable;
    assign access     = psel && penable && pready_r;
    assign wr_en      = access && pwrite;
    assign sel_dims   = (paddr == pxa_pkg::OFF_DIMS);
    assign sel_bg     = (paddr == pxa_pkg::OFF_BG);
    assign sel_fg     = (paddr == pxa_pkg::OFF_FG);
    assign sel_window_start_corner = (paddr == pxa_pkg::OFF_WINDOW_START_CORNER);
    assign sel_window_end_corner   = (paddr == pxa_pkg::OFF_WINDOW_END_CORNER);
    assign sel_destination_address  = (paddr == pxa_pkg::OFF_DESTINATION_ADDRESS);
    assign sel_ctrl   = (paddr == pxa_pkg::OFF_CTRL);
    assign sel_cmd    = (paddr == pxa_pkg::OFF_CMD);
    assign sel_status = (paddr == pxa_pkg::OFF_STATUS);
    assign sel_src    = (paddr == pxa_pkg::OFF_SRC);
    assign sel_word   = (paddr == pxa_pkg::OFF_WORD);
    assign sel_wsize  = (paddr == pxa_pkg::OFF_WSIZE);
    assign sel_count  = (paddr == pxa_pkg::OFF_COUNT);
    assign scr_off    = paddr - pxa_pkg::OFF_SCR;
    assign scr_idx    = scr_off[4:2];
    // Upper offset bits must be zero too, or addresses past the bank alias onto it
    assign sel_scr    = (paddr >= pxa_pkg::OFF_SCR) && (paddr[1:0] == 2'b00)
                        && (scr_off[7:5] == 3'b000)
                        && (scr_idx < 3'(pxa_pkg::SCR_N));
    assign hit        = sel_dims || sel_bg || sel_fg || sel_window_start_corner || sel_window_end_corner
                        || sel_destination_address || sel_ctrl || sel_cmd || sel_status
                        || sel_src || sel_word || sel_wsize || sel_count
                        || sel_scr;

    // Operand views
    wire [15:0]  width;
    wire [15:0]  height;
    wire         dims_empty;
    wire [31:0]  wsize;
    wire         clip_overlap;
    wire [31:0]  clip_dims;
    wire [31:0]  exp_word;
    wire [31:0]  status;
    wire [2:0]   cmd;
    wire         cmd_go;
    wire         run_go;
    wire [15:0]  xcnt;
    wire [15:0]  ycnt;
    wire         row_end;
    wire         last_pix;

    assign width      = dims_r[pxa_pkg::HI_LSB-1:0];
    assign height     = dims_r[31:pxa_pkg::HI_LSB];
    assign dims_empty = (width == 16'h0000) || (height == 16'h0000);
    // Window size per axis, wraps if end lies below start
    assign wsize[31:16] = window_end_corner_r[31:16] - window_start_corner_r[31:16] + 16'h0001;
    assign wsize[15:0]  = window_end_corner_r[15:0] - window_start_corner_r[15:0] + 16'h0001;
    assign cmd        = pwdata[pxa_pkg::PS_W-1:0];
    // A command written while the engine runs is dropped without an error
    assign cmd_go     = wr_en && sel_cmd && (state_r == PXA_IDLE);
    assign run_go     = cmd_go && ((cmd == pxa_pkg::CMD_FILL)
                        || (cmd == pxa_pkg::CMD_EXP) || (cmd == pxa_pkg::CMD_DRAW));
    assign xcnt       = scr_r[pxa_pkg::XCNT_IDX][15:0];
    assign ycnt       = scr_r[pxa_pkg::YCNT_IDX][15:0];
    // Changing the size while running moves the end of the run
    assign row_end    = (xcnt == width - 16'h0001);
    assign last_pix   = row_end && (ycnt == height - 16'h0001);

    // Status word; the bits not listed read as zero
    assign status = (32'(ovf_r) << pxa_pkg::ST_OVF)
                    | (32'(empty_r) << pxa_pkg::ST_EMPTY)
                    | (32'(busy_r) << pxa_pkg::ST_BUSY);

    assign rd_mux = sel_dims   ? dims_r   :
                    sel_bg     ? bg_r     :
                    sel_fg     ? fg_r     :
                    sel_window_start_corner ? window_start_corner_r :
                    sel_window_end_corner   ? window_end_corner_r   :
                    sel_destination_address  ? destination_address_r  :
                    sel_ctrl   ? {29'h0000000, ps_r} :
                    sel_status ? status   :
                    sel_src    ? src_r    :
                    sel_word   ? word_r   :
                    sel_wsize  ? wsize    :
                    sel_count  ? count_r  :
                    sel_scr    ? scr_r[scr_idx] :
                    32'h0000_0000;

    pxa_clip u_clip (
        .destination_address   (destination_address_r),
        .dims    (dims_r),
        .window_start_corner  (window_start_corner_r),
        .window_end_corner    (window_end_corner_r),
        .overlap (clip_overlap),
        .common  (clip_dims)
    );

    pxa_expand u_expand (
        .fg   (fg_r),
        .bg   (bg_r),
        .ps   (ps_r),
        .src  (src_r),
        .word (exp_word)
    );

    // APB answer: one wait-free access cycle after setup
    // Read data is taken at setup, before the access edge can write the register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= pxa_pkg::RST_WORD;
        end else begin
            pready_r  <= setup_rd;
            pslverr_r <= setup_rd && !hit;
            if (setup_rd) begin
                prdata_r <= pwrite ? pxa_pkg::RST_WORD : rd_mux;
            end
        end
    end

    // Software-owned registers; colours are never written by the engine
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bg_r     <= pxa_pkg::RST_WORD;
            fg_r     <= pxa_pkg::RST_WORD;
            window_start_corner_r <= pxa_pkg::RST_WORD;
            window_end_corner_r   <= pxa_pkg::RST_WORD;
            destination_address_r  <= pxa_pkg::RST_WORD;
            src_r    <= pxa_pkg::RST_WORD;
            ps_r     <= pxa_pkg::RST_PS;
        end else if (wr_en) begin
            if (sel_bg)     bg_r     <= pwdata;
            if (sel_fg)     fg_r     <= pwdata;
            if (sel_window_start_corner) window_start_corner_r <= pwdata;
            if (sel_window_end_corner)   window_end_corner_r   <= pwdata;
            if (sel_destination_address)  destination_address_r  <= pwdata;
            if (sel_src)    src_r    <= pwdata;
            if (sel_ctrl)   ps_r     <= pwdata[pxa_pkg::PS_W-1:0];
        end
    end

    // Dimension register: full 16-bit fields, changed only by software or clip
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dims_r <= pxa_pkg::RST_WORD;
        end else if (wr_en && sel_dims) begin
            dims_r <= pwdata;
        end else if (cmd_go && (cmd == pxa_pkg::CMD_CLIP) && clip_overlap) begin
            dims_r <= clip_dims;
        end
    end

    // No overlap keeps the old size; its value is not to be relied on
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ovf_r <= 1'b0;
        end else if (cmd_go && (cmd == pxa_pkg::CMD_CLIP)) begin
            ovf_r <= clip_overlap;
        end else if (run_go) begin
            ovf_r <= 1'b0;
        end
    end

    // Engine state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PXA_IDLE: begin
                if (run_go && !dims_empty) begin
                    state_nxt = PXA_RUN;
                end
            end
            PXA_RUN: begin
                if (last_pix) begin
                    state_nxt = PXA_IDLE;
                end
            end
            default: begin
                state_nxt = PXA_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r  <= PXA_IDLE;
            expand_r <= 1'b0;
            empty_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (run_go) begin
                expand_r <= (cmd == pxa_pkg::CMD_EXP);
                empty_r  <= dims_empty;
            end
        end
    end

    // Busy has a flop of its own so the port carries no state decode
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= (state_nxt == PXA_RUN);
        end
    end

    // Pixel count and last destination word produced
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_r <= pxa_pkg::RST_WORD;
            word_r  <= pxa_pkg::RST_WORD;
        end else if (run_go) begin
            count_r <= pxa_pkg::RST_WORD;
        end else if (state_r == PXA_RUN) begin
            count_r <= count_r + 32'h0000_0001;
            word_r  <= expand_r ? exp_word : fg_r;
        end
    end

    // Scratch bank: software words, also the engine's X and Y counters
    genvar s;
    generate
        for (s = 0; s < pxa_pkg::SCR_N; s = s + 1) begin : g_scr
            wire sw_wr;
            wire eng_wr;
            wire [31:0] eng_val;
            assign sw_wr = wr_en && sel_scr && (scr_idx == 3'(s));
            if (s == pxa_pkg::XCNT_IDX) begin : g_x
                assign eng_wr  = run_go || (state_r == PXA_RUN);
                assign eng_val = (run_go || row_end) ? pxa_pkg::RST_WORD
                                 : {16'h0000, xcnt + 16'h0001};
            end else if (s == pxa_pkg::YCNT_IDX) begin : g_y
                assign eng_wr  = run_go || ((state_r == PXA_RUN) && row_end);
                assign eng_val = run_go ? pxa_pkg::RST_WORD
                                 : {16'h0000, ycnt + 16'h0001};
            end else begin : g_keep
                // Line pattern and other words belong to software alone
                assign eng_wr  = 1'b0;
                assign eng_val = pxa_pkg::RST_WORD;
            end
            // The engine wins when software writes a counter word in the same cycle
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    scr_r[s] <= pxa_pkg::RST_WORD;
                end else if (eng_wr) begin
                    scr_r[s] <= eng_val;
                end else if (sw_wr) begin
                    scr_r[s] <= pwdata;
                end
            end
        end
    endgenerate

    // Outputs straight from flip-flops
    assign prdata   = prdata_r;
    assign pready   = pready_r;
    assign pslverr  = pslverr_r;
    assign busy     = busy_r;
    assign overflow = ovf_r;

endmodule : pxa_regs

// file: tb/pxa_regs_props.sv
// Port-level checker for the operand register block
`timescale 1ns/100ps
module pxa_regs_props (
    // Clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Engine
    input wire logic        busy,
    input wire logic        overflow
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // Shadows of the colour words as software last wrote them
    logic [31:0] fg_s_r;
    logic [31:0] bg_s_r;
    wire         wr_done  = psel && penable && pready && pwrite;
    wire         aligned  = paddr[1:0] == 2'b00;
    wire         unmapped = paddr == 8'h0C || paddr > 8'h48;
    wire         rd_done  = pready && !pwrite;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fg_s_r <= 32'h0;
            bg_s_r <= 32'h0;
        end else if (wr_done && paddr == pxa_pkg::OFF_FG) begin
            fg_s_r <= pwdata;
        end else if (wr_done && paddr == pxa_pkg::OFF_BG) begin
            bg_s_r <= pwdata;
        end
    end
    property p_ready_next;
        psel && !penable |=> pready;
    endproperty
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    property p_ready_access;
        pready |-> psel && penable;
    endproperty
    property p_err_map;
        pready && aligned |-> pslverr == unmapped;
    endproperty
    property p_err_zero;
        rd_done && pslverr |-> prdata == 32'h0;
    endproperty
    property p_ovf_run;
        busy |-> !overflow;
    endproperty
    property p_ovf_status;
        rd_done && paddr == pxa_pkg::OFF_STATUS |-> prdata[pxa_pkg::ST_OVF] == overflow;
    endproperty
    property p_fg_kept;
        rd_done && paddr == pxa_pkg::OFF_FG |-> prdata == fg_s_r;
    endproperty
    property p_bg_kept;
        rd_done && paddr == pxa_pkg::OFF_BG |-> prdata == bg_s_r;
    endproperty
    a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
    a_ready_access: assert property (p_ready_access) else $error("ready outside access");
    a_err_map: assert property (p_err_map) else $error("slave error mismatch");
    a_err_zero: assert property (p_err_zero) else $error("unmapped read not zero");
    a_ovf_run: assert property (p_ovf_run) else $error("overflow set while running");
    a_ovf_status: assert property (p_ovf_status) else $error("status overflow bit");
    a_fg_kept: assert property (p_fg_kept) else $error("foreground changed");
    a_bg_kept: assert property (p_bg_kept) else $error("background changed");
    c_write: cover property (wr_done);
    c_err: cover property (pready && pslverr);
    c_run: cover property ($rose(busy));
endmodule : pxa_regs_props

// file: tb/pxa_regs_bench.sv
// Self-checking bench for the operand register block
`timescale 1ns/100ps
module pxa_regs_bench;
    localparam logic [31:0] FG  = 32'h89AB_CDEF;
    localparam logic [31:0] BG  = 32'h1234_5678;
    localparam logic [31:0] SRC = 32'hA5C3_96F0;
    logic        clk;
    logic        resetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        busy;
    logic        overflow;
    logic [31:0] rd;
    logic        er;
    int          bad_count;
    int          n_tests;
    pxa_regs dut_u (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .busy(busy), .overflow(overflow));
    always #12.5 clk = ~clk;
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One APB transfer; ready, read data and error are taken at the same rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk("pready", 32'h1, {31'h0, pready});
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rchk
    task automatic run(input logic [2:0] c);
        int n = 0;
        wr(pxa_pkg::OFF_CMD, {29'h0, c});
        @(posedge clk);
        while (busy === 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk("idle", 32'h0, {31'h0, busy});
    endtask : run
    function automatic logic [31:0] exp_word(input int ps);
        logic [31:0] w;
        for (int i = 0; i < 32; i++) begin
            w[i] = SRC[i >> ps] ? FG[i] : BG[i % 16];
        end
        return w;
    endfunction : exp_word
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        bad_count = 0;
        n_tests = 0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        rchk(pxa_pkg::OFF_DIMS, 32'h0, "dims reset");
        rchk(pxa_pkg::OFF_CTRL, 32'h2, "ctrl reset");
        rchk(pxa_pkg::OFF_STATUS, 32'h0, "status reset");
        wr(pxa_pkg::OFF_DIMS, 32'hFFFF_FFFF);
        rchk(pxa_pkg::OFF_DIMS, 32'hFFFF_FFFF, "dims max");
        // Unmapped hole and a read-only place
        xfer(1'b1, 8'h0C, 32'h1234_5678);
        chk("err wr", 32'h1, {31'h0, er});
        rchk(8'h0C, 32'h0, "err rd");
        wr(pxa_pkg::OFF_STATUS, 32'hFFFF_FFFF);
        rchk(pxa_pkg::OFF_STATUS, 32'h0, "status ro");
        wr(pxa_pkg::OFF_SCR + 8'h0C, 32'hFFFF_FFFF);
        rchk(pxa_pkg::OFF_SCR + 8'h0C, 32'hFFFF_FFFF, "pattern");
        // Three lines of two pixels, filled then drawn
        wr(pxa_pkg::OFF_DIMS, 32'h0003_0002);
        wr(pxa_pkg::OFF_FG, FG);
        wr(pxa_pkg::OFF_BG, BG);
        for (int k = 0; k < 2; k++) begin
            run(k == 0 ? pxa_pkg::CMD_FILL : pxa_pkg::CMD_DRAW);
            rchk(pxa_pkg::OFF_COUNT, 32'h6, "count");
            rchk(pxa_pkg::OFF_WORD, FG, "fill word");
            rchk(pxa_pkg::OFF_DIMS, 32'h0003_0002, "dims kept");
            rchk(pxa_pkg::OFF_FG, FG, "fg kept");
            rchk(pxa_pkg::OFF_BG, BG, "bg kept");
        end
        // Zero width, then zero height
        for (int k = 0; k < 2; k++) begin
            wr(pxa_pkg::OFF_DIMS, k == 0 ? 32'h0005_0000 : 32'h0000_0005);
            run(pxa_pkg::CMD_FILL);
            rchk(pxa_pkg::OFF_STATUS, 32'h2, "empty");
            rchk(pxa_pkg::OFF_COUNT, 32'h0, "empty count");
        end
        // Expansion at every pixel size up to sixteen bits
        wr(pxa_pkg::OFF_DIMS, 32'h0001_0001);
        wr(pxa_pkg::OFF_SRC, SRC);
        for (int ps = 0; ps < 5; ps++) begin
            wr(pxa_pkg::OFF_CTRL, ps);
            run(pxa_pkg::CMD_EXP);
            rchk(pxa_pkg::OFF_WORD, exp_word(ps), "expand");
        end
        // Destination x 20..29, y 10..14 against window (25,12)..(40,30)
        wr(pxa_pkg::OFF_DESTINATION_ADDRESS, 32'h000A_0014);
        wr(pxa_pkg::OFF_DIMS, 32'h0005_000A);
        wr(pxa_pkg::OFF_WINDOW_START_CORNER, 32'h000C_0019);
        wr(pxa_pkg::OFF_WINDOW_END_CORNER, 32'h001E_0028);
        rchk(pxa_pkg::OFF_WSIZE, 32'h0013_0010, "wsize");
        run(pxa_pkg::CMD_CLIP);
        chk("ovf clip", 32'h1, {31'h0, overflow});
        rchk(pxa_pkg::OFF_DIMS, 32'h0003_0005, "common");
        // Window starting one column past the destination
        wr(pxa_pkg::OFF_DIMS, 32'h0005_000A);
        wr(pxa_pkg::OFF_WINDOW_START_CORNER, 32'h0000_001E);
        run(pxa_pkg::CMD_CLIP);
        chk("ovf apart", 32'h0, {31'h0, overflow});
        // Window of the single last destination pixel
        wr(pxa_pkg::OFF_DIMS, 32'h0005_000A);
        wr(pxa_pkg::OFF_WINDOW_START_CORNER, 32'h000E_001D);
        wr(pxa_pkg::OFF_WINDOW_END_CORNER, 32'h000E_001D);
        run(pxa_pkg::CMD_CLIP);
        rchk(pxa_pkg::OFF_DIMS, 32'h0001_0001, "corner");
        chk("ovf corner", 32'h1, {31'h0, overflow});
        run(pxa_pkg::CMD_FILL);
        chk("ovf cleared", 32'h0, {31'h0, overflow});
        rchk(pxa_pkg::OFF_COUNT, 32'h1, "count one");
        // A clip command written while a fill runs is dropped
        wr(pxa_pkg::OFF_DIMS, 32'h0005_000A);
        wr(pxa_pkg::OFF_CMD, {29'h0, pxa_pkg::CMD_FILL});
        run(pxa_pkg::CMD_CLIP);
        chk("ovf busy", 32'h0, {31'h0, overflow});
        rchk(pxa_pkg::OFF_DIMS, 32'h0005_000A, "dims busy");
        rchk(pxa_pkg::OFF_COUNT, 32'h0000_0032, "count busy");
        print_verdict();
    end
endmodule : pxa_regs_bench
bind pxa_regs pxa_regs_props chk_u (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy),
    .overflow(overflow));
